// file: amffic_regs.vh
`ifndef AMFFIC_REGS_VH
`define AMFFIC_REGS_VH
// Register offsets
`define AMFFIC_ADDR_IDENTITY   8'h00
`define AMFFIC_ADDR_REVISION   8'h01
`define AMFFIC_ADDR_CONTROL    8'h02
`define AMFFIC_ADDR_STATUS     8'h03
`define AMFFIC_ADDR_RSTKEY     8'h04
`define AMFFIC_ADDR_EVENT      8'h05
`define AMFFIC_ADDR_X_OUT      8'h06
`define AMFFIC_ADDR_Y_OUT      8'h07
`define AMFFIC_ADDR_Z_OUT      8'h08
`define AMFFIC_ADDR_MOT_THR    8'h09
`define AMFFIC_ADDR_TIMERS     8'h0A
`define AMFFIC_ADDR_FALL_THR   8'h0B
`define AMFFIC_ADDR_BUS_ADDR   8'h0C
// Control fields
`define AMFFIC_CTL_RANGE       7
`define AMFFIC_CTL_POLARITY    6
`define AMFFIC_CTL_STAY        5
`define AMFFIC_CTL_I2C_OFF     4
`define AMFFIC_CTL_MODE_HI     3
`define AMFFIC_CTL_MODE_LO     1
`define AMFFIC_CTL_IRQ_DIS     0
// Mode codes
`define AMFFIC_MODE_SLEEP0     3'h0
`define AMFFIC_MODE_MEAS100    3'h1
`define AMFFIC_MODE_MEAS400    3'h2
`define AMFFIC_MODE_MEAS40     3'h3
`define AMFFIC_MODE_MOTION     3'h4
`define AMFFIC_MODE_FALL100    3'h5
`define AMFFIC_MODE_FALL400    3'h6
`define AMFFIC_MODE_SLEEP7     3'h7
// Reset and factory values (arbitrary identity values)
`define AMFFIC_RST_CONTROL     8'h00
`define AMFFIC_NV_IDENTITY     7'h2A
`define AMFFIC_NV_REV_MAJOR    4'h5
`define AMFFIC_NV_REV_MINOR    4'h3
`define AMFFIC_NV_MOT_THR      8'h08
`define AMFFIC_NV_TIMERS       8'h33
`define AMFFIC_NV_FALL_THR     8'h08
`define AMFFIC_NV_BUS_ADDR     8'h1C
// Soft reset key sequence
`define AMFFIC_KEY_1           8'h02
`define AMFFIC_KEY_2           8'h0A
`define AMFFIC_KEY_3           8'h04
// Status bit positions
`define AMFFIC_STS_PORST       3
`define AMFFIC_STS_PERR        0
// FIFO geometry
`define AMFFIC_FIFO_W          27
`define AMFFIC_FIFO_D          16
`define AMFFIC_FIFO_AW         4
`endif

// file: amffic_fifo.v
`timescale 1ns/100ps
`include "amffic_regs.vh"

module amffic_fifo #(
   parameter WIDTH = `AMFFIC_FIFO_W,
   parameter DEPTH = `AMFFIC_FIFO_D,
   parameter AW    = `AMFFIC_FIFO_AW
) (
   // Clock and reset
   input  wire             core_clk,
   input  wire             rst,
   // Fill side
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   // Drain side
   output wire             out_valid,
   input  wire             out_ready,
   output reg  [WIDTH-1:0] out_data
);

   reg [WIDTH-1:0] mem_r [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr_r;
   reg [AW-1:0]    rd_ptr_r;
   reg [AW:0]      count_r;

   wire push = in_valid & in_ready;
   wire pop  = out_valid & out_ready;

   // Honest flags from the occupancy count
   assign in_ready  = (count_r != DEPTH[AW:0]);
   assign out_valid = (count_r != {(AW+1){1'b0}});

   // Storage writes, no reset needed
   always @(posedge core_clk) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data;
      end
   end

   // Pointers and count
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wr_ptr_r <= {AW{1'b0}};
         rd_ptr_r <= {AW{1'b0}};
         count_r  <= {(AW+1){1'b0}};
      end else begin
         if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
         if (pop)  rd_ptr_r <= rd_ptr_r + 1'b1;
         if (push & ~pop) count_r <= count_r + 1'b1;
         else if (pop & ~push) count_r <= count_r - 1'b1;
      end
   end

   // Combinational head word, read straight from storage at the read pointer
   always @* begin
      out_data = mem_r[rd_ptr_r];
   end

endmodule

// file: amffic_core.v
`timescale 1ns/100ps
`include "amffic_regs.vh"

// How it works
// R1: In fall sensing, irq when all axes inside window longer than dwell.
// R2: Window level is 7 bits, dwell time is 4 bits, both host-writable.
// R3: Mode code 101 gives fall sensing at 100 Hz, 110 at 400 Hz.
// R4: Axis output registers keep updating during fall sensing.
// R5: Irq source follows mode: new sample, fall, or motion.
// R6: Control bit 6 picks pin polarity: 0 active high, 1 active low.
// R7: In measurement, reading axis data clears the data-ready interrupt.
// R8: Control bit 0 set suppresses the interrupt in every mode.
// R9: Fall or motion irq stays until host reads event status.
// R10: Event status reports which axis tripped in motion sensing.
// R11: Mode 000/111 sleep; 001/010/011 measure 100/400/40 Hz; 100 motion 10 Hz.
// R12: Control bit 7 selects 8g when 0, 2g when 1, reset 0.
// R13: On motion with bit 5 clear, switch to 400 Hz measurement.
// R14: Control bit 4 set turns the I2C interface off, reset 0.
// R15: Host waits a settling interval after a mode change.
// R16: Revision register holds major in bits 7:4, minor in 3:0.
// R17: After reset, factory values load into threshold and timer registers; host-writable.
// R18: Identity register read-only, bit 7 zero, bits 6:0 fixed code.
// R19: Reading event status clears its three event bits.
// R20: Motion code: 00 none, 01 X, 10 Y, 11 Z.
// R21: One dwell timer step equals one sample period.
// R22: Axis registers hold 8-bit two's complement samples.
// R23: Dwell counter restarts when any axis leaves the window.
// R24: Window compare uses absolute axis value against unsigned level.
module amffic_core (
   // Clock and reset
   input  wire       core_clk,
   input  wire       rst,
   // Register port from the serial front end
   input  wire       reg_wr,
   input  wire       reg_rd,
   input  wire [7:0] reg_addr,
   input  wire [7:0] reg_wdata,
   output reg  [7:0] reg_rdata,
   // Filtered sample stream, one word per sample period
   input  wire       smp_valid,
   output wire       smp_ready,
   input  wire [7:0] smp_x,
   input  wire [7:0] smp_y,
   input  wire [7:0] smp_z,
   input  wire       smp_motion,
   input  wire [1:0] smp_motion_axis,
   // Factory memory image, valid after load
   input  wire       nv_parity_err,
   // Configuration outputs to the analog and serial sides
   output wire [2:0] sample_rate,
   output wire       range_2g,
   output wire       i2c_off,
   output wire       sleep_state,
   output wire       soft_reset,
   // Interrupt pin
   output wire       irq_pin
);

   ////////////////////////////////////////////////////////////////////////
   // Registers

   reg  [7:0] control_r;
   reg  [7:0] motion_trip_level_r;
   reg  [7:0] detect_timers_r;
   reg  [7:0] fall_window_level_r;
   reg  [7:0] accel_x_out_r;
   reg  [7:0] accel_y_out_r;
   reg  [7:0] accel_z_out_r;
   reg        fall_flag_r;
   reg  [1:0] motion_axis_code_r;
   reg        data_ready_r;
   reg        porst_r;
   reg  [1:0] key_stage_r;
   reg        soft_reset_r;
   reg  [3:0] fall_dwell_r;
   reg        fall_done_r;
   reg        nv_loaded_r;
   reg        perr_r;

   wire [2:0] mode = control_r[`AMFFIC_CTL_MODE_HI:`AMFFIC_CTL_MODE_LO];

   // Mode decode
   wire is_meas   = (mode == `AMFFIC_MODE_MEAS100) | (mode == `AMFFIC_MODE_MEAS400) |
                    (mode == `AMFFIC_MODE_MEAS40);                         // see R11
   wire is_motion = (mode == `AMFFIC_MODE_MOTION);                         // see R11
   wire is_fall   = (mode == `AMFFIC_MODE_FALL100) |
                    (mode == `AMFFIC_MODE_FALL400);                        // see R3
   wire is_sleep  = ~(is_meas | is_motion | is_fall);                      // see R11

   assign sample_rate = mode;
   assign range_2g    = control_r[`AMFFIC_CTL_RANGE];                      // see R12
   assign i2c_off     = control_r[`AMFFIC_CTL_I2C_OFF];                    // see R14
   assign sleep_state = is_sleep;
   assign soft_reset  = soft_reset_r;

   ////////////////////////////////////////////////////////////////////////
   // Sample FIFO; motion trigger bits ride in the word so they stay aligned

   wire        fifo_valid;
   wire [26:0] fifo_data;
   // Sleeping holds samples back; a full FIFO stalls the stream
   wire        fifo_pop = fifo_valid & ~is_sleep;

   amffic_fifo #(
      .WIDTH (`AMFFIC_FIFO_W),
      .DEPTH (`AMFFIC_FIFO_D),
      .AW    (`AMFFIC_FIFO_AW)
   ) u_fifo (
      .core_clk  (core_clk),
      .rst       (rst),
      .in_valid  (smp_valid),
      .in_ready  (smp_ready),
      .in_data   ({smp_motion, smp_motion_axis, smp_x, smp_y, smp_z}),
      .out_valid (fifo_valid),
      .out_ready (~is_sleep),
      .out_data  (fifo_data)
   );

   ////////////////////////////////////////////////////////////////////////
   // Free-fall window compare

   // Absolute value of a signed sample, -128 saturates to 127
   function [6:0] abs7;
      input [7:0] v;
      reg   [7:0] n;
      begin
         n = (~v) + 8'h01;
         if (!v[7]) abs7 = v[6:0];
         else if (n[7]) abs7 = 7'h7F;
         else abs7 = n[6:0];
      end
   endfunction

   wire [6:0] fall_window = fall_window_level_r[6:0];                      // see R2
   wire [3:0] fall_dwell  = detect_timers_r[3:0];                          // see R2
   wire in_window = (abs7(fifo_data[23:16]) <= fall_window) &
                    (abs7(fifo_data[15:8])  <= fall_window) &
                    (abs7(fifo_data[7:0])   <= fall_window);               // see R24

   // Dwell counter steps once per sample (one sample period)
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         fall_dwell_r <= 4'h0;
         fall_done_r  <= 1'b0;
      end else if (!is_fall) begin
         fall_dwell_r <= 4'h0;
         fall_done_r  <= 1'b0;
      end else if (fifo_pop) begin                                         // see R21
         if (!in_window) begin
            fall_dwell_r <= 4'h0;                                          // see R23
            fall_done_r  <= 1'b0;
         end else if (fall_dwell_r >= fall_dwell) begin
            fall_done_r  <= 1'b1;                                          // see R1
         end else begin
            fall_dwell_r <= fall_dwell_r + 4'h1;                           // see R23
         end
      end
   end

   wire fall_event = is_fall & fifo_pop & in_window &
                     (fall_dwell_r >= fall_dwell) & ~fall_done_r;          // see R1
   wire mot_event  = is_motion & fifo_pop & fifo_data[26];

   ////////////////////////////////////////////////////////////////////////
   // Register write side

   wire rd_axis  = reg_rd & ((reg_addr == `AMFFIC_ADDR_X_OUT) |
                   (reg_addr == `AMFFIC_ADDR_Y_OUT) | (reg_addr == `AMFFIC_ADDR_Z_OUT));
   wire rd_event = reg_rd & (reg_addr == `AMFFIC_ADDR_EVENT);
   wire rd_stat  = reg_rd & (reg_addr == `AMFFIC_ADDR_STATUS);

   // Host writes; motion exit overrides mode in the same cycle
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         control_r           <= `AMFFIC_RST_CONTROL;                       // see R12
         motion_trip_level_r <= 8'h00;
         detect_timers_r     <= 8'h00;
         fall_window_level_r <= 8'h00;
         nv_loaded_r         <= 1'b0;
         perr_r              <= 1'b0;
      end else if (!nv_loaded_r) begin
         // Factory image load once after reset
         motion_trip_level_r <= `AMFFIC_NV_MOT_THR;                        // see R17
         detect_timers_r     <= `AMFFIC_NV_TIMERS;                         // see R17
         fall_window_level_r <= `AMFFIC_NV_FALL_THR;                       // see R17
         perr_r              <= nv_parity_err;
         nv_loaded_r         <= 1'b1;
      end else begin
         if (reg_wr) begin
            case (reg_addr)
               `AMFFIC_ADDR_CONTROL:  control_r <= reg_wdata;
               `AMFFIC_ADDR_MOT_THR:  motion_trip_level_r <= {1'b0, reg_wdata[6:0]};
               `AMFFIC_ADDR_TIMERS:   detect_timers_r <= reg_wdata;        // see R2
               `AMFFIC_ADDR_FALL_THR: fall_window_level_r <= {1'b0, reg_wdata[6:0]};
               default: ;
            endcase
         end
         if (mot_event && !control_r[`AMFFIC_CTL_STAY]) begin
            control_r[`AMFFIC_CTL_MODE_HI:`AMFFIC_CTL_MODE_LO] <=
               `AMFFIC_MODE_MEAS400;                                       // see R13
         end
      end
   end

   // Soft reset key: three writes in order, any other value restarts
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         key_stage_r  <= 2'h0;
         soft_reset_r <= 1'b0;
      end else begin
         soft_reset_r <= 1'b0;
         if (reg_wr && reg_addr == `AMFFIC_ADDR_RSTKEY) begin
            case (key_stage_r)
               2'h0: key_stage_r <= (reg_wdata == `AMFFIC_KEY_1) ? 2'h1 : 2'h0;
               2'h1: key_stage_r <= (reg_wdata == `AMFFIC_KEY_2) ? 2'h2 : 2'h0;
               2'h2: begin
                  key_stage_r  <= 2'h0;
                  soft_reset_r <= (reg_wdata == `AMFFIC_KEY_3);
               end
               default: key_stage_r <= 2'h0;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs and event flags; a new event wins over a clearing read

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         accel_x_out_r      <= 8'h00;
         accel_y_out_r      <= 8'h00;
         accel_z_out_r      <= 8'h00;
         fall_flag_r        <= 1'b0;
         motion_axis_code_r <= 2'h0;
         data_ready_r       <= 1'b0;
         porst_r            <= 1'b1;
      end else begin
         if (fifo_pop) begin
            accel_x_out_r <= fifo_data[23:16];                             // see R4
            accel_y_out_r <= fifo_data[15:8];                              // see R22
            accel_z_out_r <= fifo_data[7:0];
         end
         // Data ready: set per sample, read of axis data clears
         if (is_meas & fifo_pop) data_ready_r <= 1'b1;                     // see R5
         else if (rd_axis | ~is_meas) data_ready_r <= 1'b0;                // see R7
         if (fall_event) fall_flag_r <= 1'b1;                              // see R1
         else if (rd_event) fall_flag_r <= 1'b0;                           // see R19
         if (mot_event) motion_axis_code_r <= fifo_data[25:24];            // see R10 R20
         else if (rd_event) motion_axis_code_r <= 2'h0;                    // see R9
         if (rd_stat) porst_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt pin

   wire irq_src = data_ready_r | fall_flag_r |
                  (motion_axis_code_r != 2'h0);                            // see R5 R9
   wire irq_act = irq_src & ~control_r[`AMFFIC_CTL_IRQ_DIS];               // see R8
   assign irq_pin = irq_act ^ control_r[`AMFFIC_CTL_POLARITY];             // see R6

   ////////////////////////////////////////////////////////////////////////
   // Read mux, registered; unmapped reads return zero

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `AMFFIC_ADDR_IDENTITY: reg_rdata <= {1'b0, `AMFFIC_NV_IDENTITY};  // see R18
            `AMFFIC_ADDR_REVISION: reg_rdata <= {`AMFFIC_NV_REV_MAJOR,
                                                 `AMFFIC_NV_REV_MINOR};      // see R16
            `AMFFIC_ADDR_CONTROL:  reg_rdata <= control_r;
            `AMFFIC_ADDR_STATUS:   reg_rdata <= {4'h0, porst_r, 2'h0, perr_r};
            `AMFFIC_ADDR_RSTKEY:   reg_rdata <= 8'h00;
            `AMFFIC_ADDR_EVENT:    reg_rdata <= {5'h00, fall_flag_r, motion_axis_code_r};
            `AMFFIC_ADDR_X_OUT:    reg_rdata <= accel_x_out_r;
            `AMFFIC_ADDR_Y_OUT:    reg_rdata <= accel_y_out_r;
            `AMFFIC_ADDR_Z_OUT:    reg_rdata <= accel_z_out_r;
            `AMFFIC_ADDR_MOT_THR:  reg_rdata <= motion_trip_level_r;
            `AMFFIC_ADDR_TIMERS:   reg_rdata <= detect_timers_r;
            `AMFFIC_ADDR_FALL_THR: reg_rdata <= fall_window_level_r;
            `AMFFIC_ADDR_BUS_ADDR: reg_rdata <= `AMFFIC_NV_BUS_ADDR;
            default:               reg_rdata <= 8'h00;
         endcase
      end
   end

endmodule

// file: amffic_core_props.sv
`timescale 1ns/100ps
`include "amffic_regs.vh"
// Port-level checks of the control core
module amffic_core_props (
   // Clock and reset
   input wire       core_clk,
   input wire       rst,
   // Register port
   input wire       reg_wr,
   input wire       reg_rd,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire [7:0] reg_rdata,
   // Stream and outputs
   input wire       smp_ready,
   input wire [2:0] sample_rate,
   input wire       range_2g,
   input wire       i2c_off,
   input wire       sleep_state,
   input wire       soft_reset,
   input wire       irq_pin
);
   reg  live_r;
   reg  pol_r;
   reg  dis_r;
   wire ctl_wr = live_r && reg_wr && reg_addr == `AMFFIC_ADDR_CONTROL;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////
   // Shadow of polarity and disable; writes at the load edge are dropped
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         live_r <= 1'b0;
         pol_r  <= 1'b0;
         dis_r  <= 1'b0;
      end else begin
         live_r <= 1'b1;
         if (ctl_wr) begin
            pol_r <= reg_wdata[6];
            dis_r <= reg_wdata[0];
         end
      end
   end
   ////////////////////////////////////////////////////////////////////
   a_reset_values: assert property (disable iff (1'b0)
      rst |-> !irq_pin && smp_ready && sample_rate == 3'h0 && !range_2g)
      else $error("state wrong during reset");
   a_sleep_decode: assert property (
      sleep_state == (sample_rate == 3'h0 || sample_rate == 3'h7))
      else $error("sleep flag does not match mode");
   a_ctrl_write: assert property (ctl_wr |=> sample_rate == $past(reg_wdata[3:1])
      && range_2g == $past(reg_wdata[7]) && i2c_off == $past(reg_wdata[4]))
      else $error("control write not applied");
   a_irq_masked: assert property (
      dis_r && $past(dis_r) && pol_r == $past(pol_r) |-> irq_pin == pol_r)
      else $error("interrupt pin active while disabled");
   a_unmapped_zero: assert property (
      reg_rd && reg_addr > `AMFFIC_ADDR_BUS_ADDR |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_ident_read: assert property (live_r && reg_rd && reg_addr == 8'h00
      |=> reg_rdata == {1'b0, `AMFFIC_NV_IDENTITY})
      else $error("identity read wrong");
   a_rev_read: assert property (live_r && reg_rd && reg_addr == 8'h01
      |=> reg_rdata == {`AMFFIC_NV_REV_MAJOR, `AMFFIC_NV_REV_MINOR})
      else $error("revision read wrong");
   a_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
      else $error("read data moved without a read");
   a_soft_pulse: assert property (soft_reset |=> !soft_reset)
      else $error("soft reset longer than one cycle");
   a_mode_source: assert property ($changed(sample_rate) |-> $past(ctl_wr)
      || ($past(sample_rate) == 3'h4 && sample_rate == 3'h2))
      else $error("mode changed without cause");
   c_motion_exit: cover property ($past(sample_rate) == 3'h4 && sample_rate == 3'h2);
   c_irq_live: cover property (!dis_r && irq_pin != pol_r);
   c_fifo_full: cover property (!smp_ready);
endmodule
bind amffic_core amffic_core_props amffic_core_props_inst (.core_clk(core_clk),
   .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .smp_ready(smp_ready),
   .sample_rate(sample_rate), .range_2g(range_2g), .i2c_off(i2c_off),
   .sleep_state(sleep_state), .soft_reset(soft_reset), .irq_pin(irq_pin));

// file: amffic_smp_src.sv
`timescale 1ns/100ps
// Filtered sample source standing in for the front end
module amffic_smp_src (
   // Clock
   input  wire       core_clk,
   // Sample stream
   output reg        smp_valid,
   input  wire       smp_ready,
   output reg  [7:0] smp_x,
   output reg  [7:0] smp_y,
   output reg  [7:0] smp_z,
   output reg  [2:0] smp_mot
);
   reg rdy_s;
   initial begin
      smp_valid = 1'b0;
      {smp_x, smp_y, smp_z, smp_mot} = 27'h0;
   end
   ////////////////////////////////////////////////////////////////////
   // Word held whole until taken; ready looked at away from the edge
   task push(input [7:0] x, input [7:0] y, input [7:0] z, input [2:0] m);
      @(posedge core_clk);
      smp_valid <= 1'b1;
      {smp_x, smp_y, smp_z, smp_mot} <= {x, y, z, m};
      rdy_s = 1'b0;
      while (!rdy_s) begin
         @(negedge core_clk);
         rdy_s = smp_ready;
         @(posedge core_clk);
      end
      smp_valid <= 1'b0;
      // Released lines inverted so stale data never looks valid
      {smp_x, smp_y, smp_z, smp_mot} <= ~{x, y, z, m};
   endtask
endmodule

// file: accel_mode_freefall_irq_ctrl_tb_top.sv
`timescale 1ns/100ps
`include "amffic_regs.vh"
`define CHK(g, e) begin n_compared = n_compared + 1; if ((g) !== (e)) begin \
   failures = failures + 1; $display("Error at %0t: got %h expected %h", $time, g, e); \
   end end
module accel_mode_freefall_irq_ctrl_tb_top;
   reg        core_clk = 1'b0;
   reg        rst;
   reg        reg_wr, reg_rd;
   reg  [7:0] reg_addr, reg_wdata, rv;
   wire [7:0] reg_rdata, smp_x, smp_y, smp_z;
   wire [2:0] smp_mot, sample_rate;
   wire       smp_valid, smp_ready, range_2g, i2c_off, sleep_state, irq_pin, soft_reset;
   reg  [3:0] n_soft;
   integer    failures, n_compared, i;
   ////////////////////////////////////////////////////////////////////
   always #2.5 core_clk = ~core_clk;
   // Count key-sequence pulses; the strobe lasts one cycle only
   always @(posedge core_clk) begin
      if (soft_reset) n_soft <= n_soft + 4'h1;
   end
   amffic_smp_src amffic_smp_src_inst (.core_clk(core_clk), .smp_valid(smp_valid),
      .smp_ready(smp_ready), .smp_x(smp_x), .smp_y(smp_y), .smp_z(smp_z),
      .smp_mot(smp_mot));
   amffic_core amffic_core_inst (.core_clk(core_clk), .rst(rst), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .smp_valid(smp_valid), .smp_ready(smp_ready),
      .smp_x(smp_x), .smp_y(smp_y), .smp_z(smp_z), .smp_motion(smp_mot[2]),
      .smp_motion_axis(smp_mot[1:0]), .nv_parity_err(1'b0),
      .sample_rate(sample_rate), .range_2g(range_2g), .i2c_off(i2c_off),
      .sleep_state(sleep_state), .soft_reset(soft_reset), .irq_pin(irq_pin));
   ////////////////////////////////////////////////////////////////////
   // Checks land just after the edge, where outputs have settled
   task step(input integer n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // Register write, then time for a new mode to settle
   task wr(input [7:0] a, input [7:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      step(4);
   endtask
   task rchk(input [7:0] a, input [7:0] e);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(posedge core_clk);
      #1 rv = reg_rdata;
      `CHK(rv, e)
   endtask
   task push(input [7:0] x, input [7:0] y, input [7:0] z, input [2:0] m);
      amffic_smp_src_inst.push(x, y, z, m);
      step(4);
   endtask
   ////////////////////////////////////////////////////////////////////
   task t_reset_map;
      rchk(8'h00, {1'b0, `AMFFIC_NV_IDENTITY});
      rchk(8'h01, {`AMFFIC_NV_REV_MAJOR, `AMFFIC_NV_REV_MINOR});
      rchk(8'h02, 8'h00);
      rchk(8'h09, `AMFFIC_NV_MOT_THR);
      rchk(8'h0A, `AMFFIC_NV_TIMERS);
      rchk(8'h0B, `AMFFIC_NV_FALL_THR);
      rchk(8'h0C, `AMFFIC_NV_BUS_ADDR);
      rchk(8'h20, 8'h00);
      rchk(8'h03, 8'h08);
      rchk(8'h03, 8'h00);
      wr(8'h04, 8'h02);
      wr(8'h04, 8'h04);
      wr(8'h04, 8'h02);
      wr(8'h04, 8'h0A);
      wr(8'h04, 8'h04);
      `CHK(n_soft, 4'h1)
      wr(8'h00, 8'hFF);
      rchk(8'h00, {1'b0, `AMFFIC_NV_IDENTITY});
      wr(8'h0A, 8'h52);
      rchk(8'h0A, 8'h52);
   endtask
   task t_modes;
      for (i = 0; i < 8; i = i + 1) begin
         wr(8'h02, 8'h91 | {4'h0, i[2:0], 1'b0});
         `CHK(sample_rate, i[2:0])
         `CHK(sleep_state, (i == 0 || i == 7))
         `CHK({range_2g, i2c_off}, 2'b11)
      end
      rchk(8'h02, 8'h9F);
   endtask
   task t_measure;
      wr(8'h02, 8'h04);
      push(8'h85, 8'h7F, 8'h01, 3'h0);
      `CHK(irq_pin, 1'b1)
      rchk(8'h06, 8'h85);
      `CHK(irq_pin, 1'b0)
      rchk(8'h07, 8'h7F);
      rchk(8'h08, 8'h01);
      wr(8'h02, 8'h44);
      push(8'h10, 8'h20, 8'h30, 3'h0);
      `CHK(irq_pin, 1'b0)
      rchk(8'h06, 8'h10);
      `CHK(irq_pin, 1'b1)
      wr(8'h02, 8'h45);
      push(8'h11, 8'h22, 8'h33, 3'h0);
      `CHK(irq_pin, 1'b1)
   endtask
   // Dwell of 2: three samples in a row inside the window fire
   task t_fall;
      wr(8'h0B, 8'h10);
      rchk(8'h0B, 8'h10);
      wr(8'h0A, 8'h32);
      wr(8'h02, 8'h0C);
      for (i = 0; i < 5; i = i + 1)
         push(8'h10, 8'hF0, (i == 2) ? 8'hEF : 8'h00, 3'h0);
      `CHK(irq_pin, 1'b0)
      push(8'h10, 8'hF0, 8'h00, 3'h0);
      `CHK(irq_pin, 1'b1)
      rchk(8'h07, 8'hF0);
      `CHK(irq_pin, 1'b1)
      rchk(8'h05, 8'h04);
      `CHK(irq_pin, 1'b0)
      rchk(8'h05, 8'h00);
   endtask
   task t_motion;
      wr(8'h02, 8'h28);
      for (i = 1; i < 4; i = i + 1) begin
         push(8'h00, 8'h00, 8'h00, {1'b1, i[1:0]});
         `CHK(irq_pin, 1'b1)
         `CHK(sample_rate, 3'h4)
         rchk(8'h05, {6'h0, i[1:0]});
      end
      `CHK(irq_pin, 1'b0)
      wr(8'h02, 8'h08);
      push(8'h00, 8'h00, 8'h00, 3'h6);
      `CHK(sample_rate, 3'h2)
      rchk(8'h05, 8'h02);
   endtask
   // Sleep holds samples in the buffer until it refuses
   task t_fifo;
      wr(8'h02, 8'h01);
      for (i = 0; i < 16; i = i + 1)
         amffic_smp_src_inst.push(i[7:0], 8'h00, 8'h00, 3'h0);
      fork
         amffic_smp_src_inst.push(8'h5A, 8'h00, 8'h00, 3'h0);
      join_none
      step(3);
      `CHK(smp_ready, 1'b0)
      rchk(8'h06, 8'h00);
      wr(8'h02, 8'h05);
      wait fork;
      step(40);
      `CHK(smp_ready, 1'b1)
      rchk(8'h06, 8'h5A);
   endtask
   task conclude;
      $display("Comparisons %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////
   initial begin
      failures = 0;
      n_compared = 0;
      n_soft = 4'h0;
      rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      step(3);
      t_reset_map;
      t_modes;
      t_measure;
      t_fall;
      t_motion;
      t_fifo;
      conclude;
   end
   // Watchdog well beyond the few hundred cycles the run needs
   initial begin
      #100000;
      failures = failures + 1;
      conclude;
   end
endmodule
